// File: lst_cfg_mem.sv
// small register memory of the system setup parameters
// assumes writes come from the command decoder; read data are registered
module lst_cfg_mem #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write port
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [7:0] wdata,
  // registered read port
  input wire logic [3:0] raddr,
  output logic [7:0] rdata,
  // all entries flat for the scan logic
  output logic [DEPTH*8-1:0] flat
);
  // storage entries
  logic [7:0] mem [DEPTH];
  // one entry per generate step, each with its own reset value
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_ent
    localparam logic [3:0] IDX = 4'(i);
    localparam logic [7:0] RV = (IDX == lst_pkg::REG_FIELD_WIDTH) ? lst_pkg::RST_FIELD_WIDTH :
                                (IDX == lst_pkg::REG_TOTAL_LINE_LENGTH) ? lst_pkg::RST_TOTAL :
                                8'h00;
    // entry store
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
        mem[i] <= RV;
      else if (we && waddr == IDX)
        mem[i] <= wdata;
    end
    assign flat[i*8 +: 8] = mem[i];
  end
  // registered read data
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= 8'h00;
    else
      rdata <= mem[raddr[2:0]];
  end
endmodule : lst_cfg_mem

// File: lst_host_model.sv
// host model: byte-wide command and parameter writer for the scan timing core
// assumes an external oscillator, so no start-up wait follows the setup command
module lst_host_model (
  // clock
  input wire logic clk,
  // write strobe toward the device
  output lst_pkg::lst_host_wr_t host_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus starts idle
  initial
  begin
    host_wr = '{wr: 1'b0, command_select_line: 1'b0, data: 8'h00};
  end
  // one write, launched just after an edge and held for one cycle
  task automatic put(input logic sel, input logic [7:0] d);
    @(posedge clk);
    #1;
    host_wr = '{wr: 1'b1, command_select_line: sel, data: d};
  endtask : put
  // strobe low; data no longer qualified, so it flips
  task automatic idle();
    @(posedge clk);
    #1;
    host_wr = '{wr: 1'b0, command_select_line: 1'b0, data: ~host_wr.data};
  endtask : idle
  // setup command then its parameters back to back, values are count minus one
  task automatic setup(input logic [7:0] p [0:5]);
    put(1'b1, lst_pkg::CMD_SYSTEM_SET);
    foreach (p[i]) put(1'b0, p[i]);
    idle();
  endtask : setup
  // memory write with a space code, which must not land in setup fields
  task automatic clear_text();
    put(1'b1, lst_pkg::CMD_MEMORY_WRITE);
    put(1'b0, 8'h20);
    idle();
  endtask : clear_text
endmodule : lst_host_model

// File: lst_pkg.sv
// package for the lcd scan timing setup block: command codes, field layout, reset values
// assumes a single 100 mhz clock domain and a byte-wide host write port
package lst_pkg;
  // command codes
  localparam logic [7:0] CMD_SYSTEM_SET = 8'h40;
  localparam logic [7:0] CMD_MEMORY_WRITE = 8'h42;
  // register offsets of the system setup group
  localparam logic [3:0] REG_SYSTEM_CONFIG_FLAGS = 4'h0;
  localparam logic [3:0] REG_FIELD_WIDTH = 4'h1;
  localparam logic [3:0] REG_FIELD_HEIGHT = 4'h2;
  localparam logic [3:0] REG_BYTES_PER_LINE = 4'h3;
  localparam logic [3:0] REG_TOTAL_LINE_LENGTH = 4'h4;
  localparam logic [3:0] REG_LINES_PER_FRAME = 4'h5;
  localparam logic [3:0] REG_LAST = 4'h7;
  // flag bit positions in system_config_flags
  localparam int BIT_CHAR_ROM_SELECT = 0;
  localparam int BIT_CHAR_HEIGHT_SELECT = 2;
  localparam int BIT_TWO_PANEL = 3;
  localparam int BIT_TOP_LINE_COMP = 5;
  localparam int BIT_MODE_LSB = 6;
  // field width nibble in the field width register
  localparam int FW_MSB = 3;
  // reset values
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_FIELD_WIDTH = 8'h07;
  localparam logic [7:0] RST_BYTES = 8'h00;
  localparam logic [7:0] RST_TOTAL = 8'h02;
  localparam logic [7:0] RST_LINES = 8'h00;
  // scan divider selections (4, 8 or 16 system clocks per divider tick)
  localparam logic [1:0] DIV_4 = 2'h0;
  localparam logic [1:0] DIV_8 = 2'h1;
  localparam logic [1:0] DIV_16 = 2'h2;
  localparam logic [4:0] DIV4_CNT = 5'h03;
  localparam logic [4:0] DIV8_CNT = 5'h07;
  localparam logic [4:0] DIV16_CNT = 5'h0f;
  // minimum extra addresses beyond displayed bytes per line
  localparam logic [8:0] LINE_MARGIN = 9'h002;
  // host write strobe bundle
  typedef struct packed {
    logic wr;
    logic command_select_line;
    logic [7:0] data;
  } lst_host_wr_t;
  // color depth modes
  typedef enum logic [1:0] {LST_BPP1, LST_BPP2, LST_BPP4} lst_bpp_t;
endpackage : lst_pkg

// File: lst_scan_timing.sv
// lcd scan timing core: host command/parameter intake, setup registers, line and frame scan
// assumes host writes are synchronous single-cycle strobes on clk
module lst_scan_timing #(
  parameter int REGS = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host write port
  input wire lst_pkg::lst_host_wr_t host_wr,
  // scan setup not carried by parameters
  input wire logic [1:0] scan_clock_divider,
  input wire logic [3:0] panel_pixel_pos,
  // readback of the setup group
  input wire logic [3:0] read_addr,
  output logic [7:0] read_data,
  // scan outputs
  output logic line_pulse_output,
  output logic frame_start,
  output logic pixel_blank,
  output logic [7:0] line_count,
  output logic [8:0] addr_count,
  output logic [7:0] system_config_flags,
  output logic in_setup
);
  // intake state
  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_MEMORY_WRITE_COMMAND} st_t;
  st_t state;
  st_t next_state;
  logic [3:0] param_idx; // next field to store
  logic [3:0] next_param_idx;
  logic [REGS*8-1:0] cfg; // flat setup fields
  logic [7:0] mem_rdata;
  // decode of host strobes
  wire is_cmd = host_wr.wr && host_wr.command_select_line;
  wire is_par = host_wr.wr && !host_wr.command_select_line;
  wire store_par = is_par && state == S_SETUP && param_idx <= lst_pkg::REG_LAST;
  // setup field views (counts stored as count minus one)
  wire [7:0] flags = cfg[lst_pkg::REG_SYSTEM_CONFIG_FLAGS*8 +: 8];
  wire [3:0] char_field_width = cfg[lst_pkg::REG_FIELD_WIDTH*8 +: 4];
  wire [7:0] bytes_m1 = cfg[lst_pkg::REG_BYTES_PER_LINE*8 +: 8];
  wire [7:0] total_line_length = cfg[lst_pkg::REG_TOTAL_LINE_LENGTH*8 +: 8];
  wire [7:0] lines_m1 = cfg[lst_pkg::REG_LINES_PER_FRAME*8 +: 8];
  // counts are register value plus one
  wire [8:0] bytes_cnt = {1'b0, bytes_m1} + 9'h001;
  wire [8:0] total_cnt = {1'b0, total_line_length} + 9'h001;
  // a too-short line is stretched to the least legal length so scanning never stalls
  wire [8:0] line_len = (total_cnt < bytes_cnt + lst_pkg::LINE_MARGIN) ?
                        bytes_cnt + lst_pkg::LINE_MARGIN : total_cnt;
  wire lst_pkg::lst_bpp_t bpp = lst_pkg::lst_bpp_t'(flags[lst_pkg::BIT_MODE_LSB +: 2]);
  // full-width field: field width at least 8 (stored 7), else the last byte of a line may be a partial column
  wire wide_field = char_field_width >= 4'h7;
  // extra divider ticks per address step by depth: 0 at 1 bpp, 1 at 2 bpp, 2 at 4 bpp
  wire [4:0] fetch_extra = (bpp == lst_pkg::LST_BPP4) ? 5'h02 :
                           (bpp == lst_pkg::LST_BPP2) ? 5'h01 : 5'h00;
  // scan divider terminal count
  wire [4:0] div_end = (scan_clock_divider == lst_pkg::DIV_16) ? lst_pkg::DIV16_CNT :
                       (scan_clock_divider == lst_pkg::DIV_8) ? lst_pkg::DIV8_CNT :
                       lst_pkg::DIV4_CNT;
  // scan counters
  logic [4:0] div_cnt;
  logic [4:0] fetch_cnt;
  logic [8:0] col;
  logic [7:0] row;
  wire div_tick = div_cnt == div_end;
  // one address step takes one tick at 1 bpp, more at deeper modes
  wire step = div_tick && fetch_cnt == fetch_extra;
  // a line shortened mid-scan ends at the next step instead of wrapping the column counter
  wire line_end = step && col >= line_len - 9'h001;
  wire frame_end = line_end && row == lines_m1;
  // blank area: beyond displayed bytes or the partial column of the last field
  wire last_byte = col == bytes_m1[7:0] + 9'h000;
  wire partial = last_byte && !wide_field && panel_pixel_pos > char_field_width;
  wire next_blank = col >= bytes_cnt || partial;
  // next state of intake
  always_comb
  begin
    next_state = state;
    next_param_idx = param_idx;
    if (is_cmd)
    begin
      if (host_wr.data == lst_pkg::CMD_SYSTEM_SET)
      begin
        next_state = S_SETUP;
        next_param_idx = lst_pkg::REG_SYSTEM_CONFIG_FLAGS;
      end
      else if (host_wr.data == lst_pkg::CMD_MEMORY_WRITE)
        next_state = S_MEMORY_WRITE_COMMAND;
      else
        next_state = S_IDLE;
    end
    else if (store_par)
      next_param_idx = param_idx + 4'h1;
  end
  // parameter storage and readback
  lst_cfg_mem #(.DEPTH(REGS)) u_mem (
    .clk(clk),
    .rst(rst),
    .we(store_par),
    .waddr(param_idx),
    .wdata(host_wr.data),
    .raddr(read_addr),
    .rdata(mem_rdata),
    .flat(cfg)
  );
  // intake registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= S_IDLE;
      param_idx <= 4'h0;
    end
    else
    begin
      state <= next_state;
      param_idx <= next_param_idx;
    end
  end
  // divider and fetch counters
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_cnt <= 5'h00;
      fetch_cnt <= 5'h00;
    end
    else
    begin
      div_cnt <= div_tick ? 5'h00 : div_cnt + 5'h01;
      if (div_tick)
        fetch_cnt <= (fetch_cnt == fetch_extra) ? 5'h00 : fetch_cnt + 5'h01;
    end
  end
  // horizontal and vertical scan
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      col <= 9'h000;
      row <= 8'h00;
    end
    else if (step)
    begin
      col <= line_end ? 9'h000 : col + 9'h001;
      if (line_end)
        row <= frame_end ? 8'h00 : row + 8'h01;
    end
  end
  // registered outputs
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      line_pulse_output <= 1'b0;
      frame_start <= 1'b0;
      pixel_blank <= 1'b1;
      line_count <= 8'h00;
      addr_count <= 9'h000;
      system_config_flags <= lst_pkg::RST_FLAGS;
      read_data <= 8'h00;
      in_setup <= 1'b0;
    end
    else
    begin
      line_pulse_output <= line_end;
      frame_start <= frame_end;
      pixel_blank <= next_blank;
      line_count <= row;
      addr_count <= col;
      system_config_flags <= flags;
      read_data <= mem_rdata;
      in_setup <= state == S_SETUP;
    end
  end
  // line pulse follows every line end by one cycle
  a_line_pulse: assert property (@(posedge clk) disable iff (rst)
    line_end |=> line_pulse_output) else $error("line pulse missing");
  // row wraps to zero after the last line
  a_frame_wrap: assert property (@(posedge clk) disable iff (rst)
    frame_end |=> row == 8'h00) else $error("frame did not wrap");
  // command strobe with system setup enters setup at first field
  a_setup_enter: assert property (@(posedge clk) disable iff (rst)
    is_cmd && host_wr.data == lst_pkg::CMD_SYSTEM_SET |=> state == S_SETUP && param_idx == 4'h0)
    else $error("setup entry wrong");
  // parameter advances the field index
  a_param_step: assert property (@(posedge clk) disable iff (rst)
    store_par |=> param_idx == $past(param_idx) + 4'h1) else $error("index stuck");
  // first parameter lands in the flags output two cycles later
  a_flags_load: assert property (@(posedge clk) disable iff (rst)
    store_par && param_idx == 4'h0 |=> ##1 system_config_flags == $past(host_wr.data, 2))
    else $error("flags not stored");
  // parameter writes never change state
  a_param_no_cmd: assert property (@(posedge clk) disable iff (rst)
    is_par |=> state == $past(state)) else $error("parameter acted as command");
  // columns past displayed bytes show blank
  a_blank_tail: assert property (@(posedge clk) disable iff (rst)
    col >= bytes_cnt |=> pixel_blank) else $error("tail not blank");
  // a scanned line never ends before bytes plus margin columns
  a_line_min: assert property (@(posedge clk) disable iff (rst)
    line_end |-> col + 9'h001 >= bytes_cnt + lst_pkg::LINE_MARGIN) else $error("line too short");
  // at least four clocks between address steps
  a_step_div: assert property (@(posedge clk) disable iff (rst)
    step |=> !step [*3]) else $error("step off divider");
endmodule : lst_scan_timing

// File: tb_top.sv
// bench for the scan timing core: reset values, setup readback, refusal, line period
// assumes lst_host_model drives the host port; clock 100 mhz
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst;
  lst_pkg::lst_host_wr_t host_wr;
  logic [1:0] scan_clock_divider;
  logic [3:0] panel_pixel_pos;
  logic [3:0] read_addr;
  logic [7:0] read_data;
  logic line_pulse_output;
  logic frame_start;
  logic pixel_blank;
  logic [7:0] line_count;
  logic [8:0] addr_count;
  logic [7:0] system_config_flags;
  logic in_setup;
  int mismatches = 0;
  int cmp_count = 0;
  int seed = 62882;
  int since = 0; // cycles since the last line pulse
  int lines = 0; // line pulses since the last frame start
  bit scan_chk = 1'b0; // scan outputs are compared while set
  logic [15:0] end_q [$]; // expected last column of a line
  logic rd_req = 1'b0;
  logic [1:0] rd_pipe = 2'h0; // read requests in flight
  logic [15:0] rd_q [$]; // expected read data, oldest first
  logic [15:0] per_q [$]; // expected line periods
  logic [7:0] cfg [0:5]; // parameters of the current setup
  // host side partner
  lst_host_model host (.clk(clk), .host_wr(host_wr));
  // device under test
  lst_scan_timing uut (.clk(clk), .rst(rst), .host_wr(host_wr),
    .scan_clock_divider(scan_clock_divider), .panel_pixel_pos(panel_pixel_pos),
    .read_addr(read_addr), .read_data(read_data), .line_pulse_output(line_pulse_output),
    .frame_start(frame_start), .pixel_blank(pixel_blank), .line_count(line_count),
    .addr_count(addr_count),
    .system_config_flags(system_config_flags), .in_setup(in_setup));
  // clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // single compare point
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check
  // verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  // monitor: readback two edges after request, line period at the first pulse after each setup's period is queued
  always @(posedge clk)
  begin
    rd_pipe <= {rd_pipe[0], rd_req};
    if (rd_pipe[1]) check(16'(read_data), rd_q.pop_front());
    if (scan_chk) check(16'(pixel_blank), 16'(addr_count > 9'(cfg[3])));
    since <= since + 1;
    if (line_pulse_output === 1'b1)
    begin
      since <= 1;
      lines <= (frame_start === 1'b1) ? 0 : lines + 1;
      if (scan_chk)
      begin
        check(16'(frame_start), 16'(lines == int'(cfg[5])));
        check(16'(line_count), 16'(lines));
      end
      if (per_q.size() > 0)
      begin
        check(16'(since), per_q.pop_front());
        check(16'(addr_count), end_q.pop_front());
      end
    end
  end
  // one readback request with its expected value noted
  task automatic rd(input logic [3:0] a, input logic [7:0] want);
    @(posedge clk);
    #1;
    read_addr = a;
    rd_req = 1'b1;
    rd_q.push_back(16'(want));
    @(posedge clk);
    #1;
    rd_req = 1'b0;
  endtask : rd
  // bounded wait for the next line pulse
  task automatic wait_pulse();
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (line_pulse_output !== 1'b1 && n < 2000);
    #1;
    if (n >= 2000)
    begin
      mismatches++;
      $display("wrong value at %0t: no line pulse", $time);
    end
  endtask : wait_pulse
  // main sequence
  initial
  begin
    rst = 1'b1;
    scan_clock_divider = lst_pkg::DIV_4;
    panel_pixel_pos = 4'h0;
    read_addr = 4'h0;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    rd(lst_pkg::REG_FIELD_WIDTH, lst_pkg::RST_FIELD_WIDTH);
    rd(lst_pkg::REG_TOTAL_LINE_LENGTH, lst_pkg::RST_TOTAL);
    rd(lst_pkg::REG_SYSTEM_CONFIG_FLAGS, lst_pkg::RST_FLAGS);
    // every depth against every divider; 2 bpp uses a too-short total line
    for (int b = 0; b < 3; b++)
      for (int d = 0; d < 3; d++)
      begin
        scan_clock_divider = 2'(d);
        panel_pixel_pos = 4'($random(seed));
        cfg = '{{2'(b), 6'h38}, 8'h07, 8'($random(seed)),
          (b == 1) ? 8'h04 : 8'h01, (b == 1) ? 8'h00 : 8'h05, 8'h01};
        host.setup(cfg);
        check(16'(system_config_flags), {8'h00, 2'(b), 6'h38});
        check(16'(in_setup), 16'h0001);
        foreach (cfg[i]) rd(4'(i), cfg[i]);
        wait_pulse();
        wait_pulse();
        per_q.push_back(16'(((b == 1) ? 7 : 6) * (4 << d) * (b + 1)));
        end_q.push_back(16'((b == 1) ? 6 : 5));
        scan_chk = 1'b1;
        wait_pulse();
        wait_pulse();
        scan_chk = 1'b0;
      end
    // memory write parameters stay out of the setup fields
    host.clear_text();
    @(posedge clk);
    #1;
    check(16'(in_setup), 16'h0000);
    rd(lst_pkg::REG_SYSTEM_CONFIG_FLAGS, 8'hb8);
    repeat (4) @(posedge clk);
    finish_test();
  end
  // watchdog well beyond the expected run
  initial
  begin
    #400000;
    mismatches++;
    finish_test();
  end
endmodule : tb_top
